// [hw/adc_xfer_pkg.sv]
package adc_xfer_pkg;

  // Data path widths
  localparam int RES_W        = 12;
  localparam int CMD_W        = 8;
  localparam int ADDR_W       = 4;
  localparam int FMT_W        = 3;
  localparam int CNT_W        = 5;
  localparam int BIT_W        = 4;

  // Command byte layout: address first, then length code and order
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_LEN_LSB  = 2;
  localparam int CMD_ORD_BIT  = 1;

  // Format word layout {length code, lsb first}
  localparam int FMT_LEN_LSB  = 1;
  localparam int FMT_ORD_BIT  = 0;

  // Frame edge positions
  localparam int ADDR_RISE    = 4;
  localparam int SAMPLE_FALL  = 4;

  // Output length codes
  localparam logic [1:0] LEN_CODE_8  = 2'h1;
  localparam logic [1:0] LEN_CODE_16 = 2'h3;
  localparam logic [CNT_W-1:0] FRAME_LEN_8  = 5'h08;
  localparam logic [CNT_W-1:0] FRAME_LEN_12 = 5'h0C;
  localparam logic [CNT_W-1:0] FRAME_LEN_16 = 5'h10;

  // Select setup interval
  localparam int  CLK_FREQ_MHZ  = 100;
  localparam real SETUP_TIME_US = 1.425;
  localparam int  SETUP_CYCLES  =
    int'($ceil(SETUP_TIME_US * real'(CLK_FREQ_MHZ)));
  localparam int  SETUP_LAT     = 4;
  localparam int  SETUP_W       = 8;

  // Converter timing and buffering
  localparam int  STEP_CYCLES   = 8;
  localparam int  FIFO_DEPTH    = 8;

  // Values after reset
  localparam logic             EOC_RST  = 1'b1;
  localparam logic [RES_W-1:0] HOLD_RST = 12'h000;
  localparam logic [FMT_W-1:0] FMT_RST  = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CONV  = 3'b010,
    ST_STORE = 3'b100
  } conv_state_t;

  function automatic logic [CNT_W-1:0] frame_len(input logic [1:0] code);
    case (code)
      LEN_CODE_8:  frame_len = FRAME_LEN_8;
      LEN_CODE_16: frame_len = FRAME_LEN_16;
      default:     frame_len = FRAME_LEN_12;
    endcase
  endfunction

endpackage

// [hw/adc_fifo.sv]
`timescale 1ns/1ps
module adc_fifo #(
  parameter int W = 15,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wr;
    logic [AW:0]         rd;
  } fifo_t;

  fifo_t s_q;
  fifo_t s_d;
  logic  full;
  logic  empty;

  assign empty       = (s_q.wr == s_q.rd);
  assign full        = (s_q.wr[AW] != s_q.rd[AW]) &&
                       (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = s_q.mem[s_q.rd[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (in_valid_i && !full) begin
      s_d.mem[s_q.wr[AW-1:0]] = in_data_i;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [hw/adc_serial_ctrl.sv]
// Operation
// [RULE1] The result output is driven only while select is low.
// [RULE2] On select low the first bit of the previous result is shown.
// [RULE3] Each later transfer-clock fall moves the output to the next bit.
// [RULE4] Conversion-done drops after the last transfer-clock fall.
// [RULE5] Conversion-done rises once the new result is ready to send.
// [RULE6] Eight command bits are taken on the first eight rising edges.
// [RULE7] The channel address is valid right after the fourth rise.
// [RULE8] Sampling runs from the fourth fall to the last fall of a frame.
// [RULE9] The eleven remaining result bits follow on successive falls.
// [RULE10] The last fall hands the conversion to the internal sequencer.
// [RULE11] Select low clears the frame logic; select high disables it.
// [RULE12] The four address bits arrive MSB first on the first rises.
// [RULE13] Control inputs are ignored for the setup time after select.
// [RULE14] Bits after the address set output order and frame length.
// [RULE15] The last result is held for shifting out in the next frame.
`timescale 1ns/1ps
module adc_serial_ctrl
  import adc_xfer_pkg::*;
#(
  parameter int STEPS = adc_xfer_pkg::STEP_CYCLES,
  parameter int DEPTH = adc_xfer_pkg::FIFO_DEPTH
) (
  input  wire logic                            clk_i,
  input  wire logic                            nrst_i,
  input  wire logic                            sclk_i,
  input  wire logic                            cs_n_i,
  input  wire logic                            din_i,
  output logic                                 dout_o,
  output logic                                 dout_oe_o,
  output logic                                 eoc_o,
  output logic [adc_xfer_pkg::ADDR_W-1:0]      mux_addr_o,
  output logic                                 sample_o,
  output logic [adc_xfer_pkg::RES_W-1:0]       dac_code_o,
  input  wire logic                            cmp_i
);
  import adc_xfer_pkg::*;

  localparam int STEP_W = $clog2(STEPS + 1);
  localparam int FIFO_W = RES_W + FMT_W;

  // Rising-edge frame state on the transfer clock
  typedef struct packed {
    logic [BIT_W-1:0]  rise_cnt;
    logic [CMD_W-1:0]  cmd;
    logic [ADDR_W-1:0] addr;
  } rise_t;

  // Falling-edge frame state on the transfer clock
  typedef struct packed {
    logic [CNT_W-1:0] fall_cnt;
    logic             sample;
  } fall_t;

  // Request handed to the system clock; survives the end of the frame
  typedef struct packed {
    logic             tgl;
    logic [FMT_W-1:0] fmt;
  } req_t;

  // System clock state
  typedef struct packed {
    logic               cs_s1;
    logic               cs_s2;
    logic               tg_s1;
    logic               tg_s2;
    logic               tg_s3;
    logic               cmp_s1;
    logic               cmp_s2;
    logic [SETUP_W-1:0] setup_cnt;
    logic               setup_done;
    conv_state_t        state;
    logic [RES_W-1:0]   sar;
    logic [BIT_W-1:0]   bit_idx;
    logic [STEP_W-1:0]  step;
    logic [FMT_W-1:0]   req_fmt;
    logic               eoc;
    logic [RES_W-1:0]   hold;
    logic [FMT_W-1:0]   hold_fmt;
  } sys_t;

  rise_t r_q;
  rise_t r_d;
  fall_t f_q;
  fall_t f_d;
  req_t  k_q;
  req_t  k_d;
  sys_t  s_q;
  sys_t  s_d;

  logic                 link_rst_n;
  logic [CNT_W-1:0]     len;
  logic [CNT_W-1:0]     frm_len;
  logic                 last_fall;
  logic [BIT_W-1:0]     bit_pos;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic [FIFO_W-1:0]    fifo_out_data;
  logic                 conv_req;

  // Frame logic is held cleared while select is high and during the
  // setup interval; the transfer clock is idle then, so the release of
  // this reset cannot meet a clock edge when the host keeps the setup.
  assign link_rst_n = nrst_i && !cs_n_i && s_q.setup_done; // [RULE11] [RULE13]

  // The hold word only changes between frames, so it is stable while read
  assign len       = frame_len(s_q.hold_fmt[FMT_LEN_LSB +: 2]); // [RULE14]
  // Frame length comes from this frame's command; its bits are complete
  // by the eighth rise, ahead of the earliest possible last fall
  assign frm_len   = frame_len(r_q.cmd[CMD_LEN_LSB +: 2]); // [RULE14]
  assign last_fall = (f_q.fall_cnt == frm_len - 5'h01);

  // Output bit selection by order and position
  always_comb begin
    bit_pos = f_q.fall_cnt[BIT_W-1:0];
    if (!s_q.hold_fmt[FMT_ORD_BIT]) begin
      bit_pos = BIT_W'(RES_W - 1) - f_q.fall_cnt[BIT_W-1:0];
    end
  end

  always_comb begin
    dout_o = 1'b0;
    if ((f_q.fall_cnt < CNT_W'(RES_W)) && (f_q.fall_cnt < len)) begin
      dout_o = s_q.hold[bit_pos]; // [RULE2] [RULE3] [RULE9]
    end
  end

  // Three-state control follows select with no clock in between
  assign dout_oe_o  = !cs_n_i; // [RULE1]
  assign eoc_o      = s_q.eoc;
  assign mux_addr_o = r_q.addr;
  assign sample_o   = f_q.sample;
  assign dac_code_o = s_q.sar;

  // Command capture on rising transfer-clock edges
  always_comb begin
    r_d = r_q;
    if (r_q.rise_cnt < BIT_W'(CMD_W)) begin
      r_d.cmd      = {r_q.cmd[CMD_W-2:0], din_i}; // [RULE6]
      r_d.rise_cnt = r_q.rise_cnt + 4'h1;
      if (r_q.rise_cnt == BIT_W'(ADDR_RISE - 1)) begin
        r_d.addr = {r_q.cmd[ADDR_W-2:0], din_i}; // [RULE7] [RULE12]
      end
    end
  end

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      r_q <= '0; // [RULE11]
    end else begin
      r_q <= r_d;
    end
  end

  // Output shifting and sampling window on falling edges
  always_comb begin
    f_d = f_q;
    if (f_q.fall_cnt < frm_len) begin
      f_d.fall_cnt = f_q.fall_cnt + 5'h01; // [RULE3]
      if (f_q.fall_cnt == CNT_W'(SAMPLE_FALL - 1)) begin
        f_d.sample = 1'b1; // [RULE8]
      end
      if (last_fall) begin
        f_d.sample = 1'b0; // [RULE8]
      end
    end
  end

  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      f_q <= '0; // [RULE11]
    end else begin
      f_q <= f_d;
    end
  end

  // The request toggle and its format outlive the frame reset so that
  // the system side can read them after select has gone high.
  always_comb begin
    k_d = k_q;
    if (link_rst_n && (f_q.fall_cnt < frm_len) && last_fall) begin
      k_d.tgl = !k_q.tgl; // [RULE10]
      k_d.fmt = {r_q.cmd[CMD_LEN_LSB +: 2],
                 r_q.cmd[CMD_ORD_BIT]}; // [RULE14]
    end
  end

  always_ff @(negedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  assign conv_req = s_q.tg_s2 ^ s_q.tg_s3;

  // Result buffer between the sequencer and the hold register
  adc_fifo #(
    .W (FIFO_W),
    .D (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (s_q.state == ST_STORE),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({s_q.req_fmt, s_q.sar}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Hold may only change while no frame is running
  assign fifo_out_ready = s_q.cs_s2;

  always_comb begin
    s_d = s_q;
    s_d.cs_s1  = cs_n_i;
    s_d.cs_s2  = s_q.cs_s1;
    s_d.tg_s1  = k_q.tgl;
    s_d.tg_s2  = s_q.tg_s1;
    s_d.tg_s3  = s_q.tg_s2;
    s_d.cmp_s1 = cmp_i;
    s_d.cmp_s2 = s_q.cmp_s1;

    // Setup timer; the synchroniser delay is taken off the count
    if (s_q.cs_s2) begin
      s_d.setup_cnt  = '0;
      s_d.setup_done = 1'b0; // [RULE11]
    end else if (s_q.setup_cnt <
                 SETUP_W'(SETUP_CYCLES - SETUP_LAT)) begin
      s_d.setup_cnt = s_q.setup_cnt + 8'h01; // [RULE13]
    end else begin
      s_d.setup_done = 1'b1; // [RULE13]
    end

    // A fresh result leaves the buffer only between frames
    if (fifo_out_valid && fifo_out_ready) begin
      s_d.hold     = fifo_out_data[RES_W-1:0]; // [RULE15]
      s_d.hold_fmt = fifo_out_data[FIFO_W-1:RES_W];
      s_d.eoc      = 1'b1; // [RULE5]
    end

    case (s_q.state)
      ST_IDLE: begin
        if (conv_req) begin
          s_d.state   = ST_CONV; // [RULE10]
          s_d.sar     = 12'h800;
          s_d.bit_idx = BIT_W'(RES_W - 1);
          s_d.step    = '0;
          s_d.req_fmt = k_q.fmt;
        end
      end
      ST_CONV: begin
        if (s_q.step == STEP_W'(STEPS - 1)) begin
          s_d.step = '0;
          if (!s_q.cmp_s2) begin
            s_d.sar[s_q.bit_idx] = 1'b0;
          end
          if (s_q.bit_idx == '0) begin
            s_d.state = ST_STORE;
          end else begin
            s_d.bit_idx = s_q.bit_idx - 4'h1;
            s_d.sar[s_q.bit_idx - 4'h1] = 1'b1;
          end
        end else begin
          s_d.step = s_q.step + 1'b1;
        end
      end
      ST_STORE: begin
        // A full buffer stalls the sequencer here
        if (fifo_in_ready) begin
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // A request while busy is dropped, but done still falls
    if (conv_req) begin
      s_d.eoc = 1'b0; // [RULE4]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q          <= '0;
      s_q.cs_s1    <= 1'b1;
      s_q.cs_s2    <= 1'b1;
      s_q.state    <= ST_IDLE;
      s_q.eoc      <= EOC_RST;
      s_q.hold     <= HOLD_RST;
      s_q.hold_fmt <= FMT_RST;
      s_q.req_fmt  <= FMT_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [sim/adc_serial_ctrl_sva.sv]
`timescale 1ns/1ps
module adc_serial_ctrl_chk
  import adc_xfer_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       nrst_i,
  input wire logic                       sclk_i,
  input wire logic                       cs_n_i,
  input wire logic                       din_i,
  input wire logic                       dout_o,
  input wire logic                       dout_oe_o,
  input wire logic                       eoc_o,
  input wire logic [adc_xfer_pkg::ADDR_W-1:0] mux_addr_o,
  input wire logic                       sample_o,
  input wire logic [adc_xfer_pkg::RES_W-1:0]  dac_code_o,
  input wire logic                       cmp_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // First SAR trial is mid scale
  sequence conv_start;
    ##[0:2] dac_code_o == 12'h800;
  endsequence
  sequence conv_busy;
    !eoc_o [*8];
  endsequence
  oe_follow_a: assert property (
    dout_oe_o == !cs_n_i) else $error("output enable off select");
  bit_on_fall_a: assert property (
    !cs_n_i && $past(!cs_n_i) && $changed(dout_o) |-> !sclk_i)
    else $error("result bit moved off a falling edge");
  addr_clear_a: assert property (
    cs_n_i [*2] |-> mux_addr_o == '0) else $error("address kept");
  addr_rise_a: assert property (
    $changed(mux_addr_o) && mux_addr_o != '0 |-> !cs_n_i && sclk_i)
    else $error("address taken off a rising edge");
  sample_start_a: assert property (
    $rose(sample_o) |-> !cs_n_i && !sclk_i) else $error("sample start");
  sample_idle_a: assert property (
    cs_n_i [*2] |-> !sample_o) else $error("sampling outside frame");
  done_rise_a: assert property (
    $rose(eoc_o) |-> $past(cs_n_i, 2) && cs_n_i)
    else $error("done raised inside a frame");
  conv_start_a: assert property (
    $fell(eoc_o) |-> conv_start) else $error("conversion not started");
  conv_busy_a: assert property (
    $fell(eoc_o) |-> conv_busy) else $error("done returned too early");
  frame_done_a: assert property (
    $fell(eoc_o) |-> !sample_o) else $error("done fell while sampling");
endmodule

// [sim/adc_host_model.sv]
`timescale 1ns/1ps
module adc_host_model (
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             din_o,
  input  wire logic        dout_i,
  input  wire logic        dout_oe_i,
  input  wire logic [3:0]  mux_addr_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Clock stands low between frames; early pulses break the setup rule
  task automatic frame(input logic [7:0] cmd, input int falls,
                       input int early, output logic [15:0] bits,
                       output logic [3:0] addr);
    logic rd;
    rd = 1'b0;
    bits = '0;
    addr = '0;
    cs_n_o = 1'b0;
    repeat (early) begin
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    #1500;
    for (int k = 0; k < falls; k++) begin
      din_o = (k < 8) ? cmd[7-k] : ~din_o;
      #80 sclk_o = 1'b1;
      rd = dout_oe_i ? dout_i : ~rd;
      bits[k] = rd;
      if (k == 4) addr = mux_addr_i;
      #80 sclk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule

// [sim/serial_adc_transfer_control_tb_top.sv]
`timescale 1ns/1ps
module serial_adc_transfer_control_tb_top;
  import adc_xfer_pkg::*;
  logic              clk_i, nrst_i, sclk, cs_n, din, dout, dout_oe;
  logic              eoc, smp, cmp;
  logic [ADDR_W-1:0] addr;
  logic [RES_W-1:0]  dac, target, hold_t;
  logic [2:0]        hold_f;
  int                n_mismatch = 0;
  int                n_compared = 0;
  adc_serial_ctrl #(.STEPS(4), .DEPTH(FIFO_DEPTH)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .eoc_o(eoc),
    .mux_addr_o(addr), .sample_o(smp), .dac_code_o(dac), .cmp_i(cmp));
  adc_host_model HOST (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
    .dout_oe_i(dout_oe), .mux_addr_i(addr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Ideal comparator, so the result must equal the target
  always @(posedge clk_i) cmp <= (target >= dac);
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic int flen(input logic [2:0] f);
    flen = (f[2:1] == 2'h1) ? 8 : (f[2:1] == 2'h3) ? 16 : 12;
  endfunction
  function automatic logic [15:0] exp_bits(input logic [11:0] t,
                                           input logic [2:0] f, input int n);
    exp_bits = '0;
    for (int k = 0; k < n; k++)
      if (k < 12 && k < flen(f)) exp_bits[k] = f[0] ? t[k] : t[11-k];
  endfunction
  task automatic run(input logic [3:0] a, input logic [2:0] f,
                     input int falls, input int early, input logic [11:0] t);
    logic [15:0] got;
    logic [3:0]  ga;
    @(posedge clk_i);
    target <= t;
    HOST.frame({a, f, 1'b0}, falls, early, got, ga);
    chk("dout", exp_bits(hold_t, hold_f, falls), got);
    chk("addr", {12'h000, a}, {12'h000, ga});
    if (falls < flen(f)) begin
      repeat (200) @(posedge clk_i);
      chk("eoc idle", 16'h0001, {15'h0, eoc});
    end else begin
      chk("eoc low", 16'h0000, {15'h0, eoc});
      for (int i = 0; i < 300 && eoc !== 1'b1; i++) @(posedge clk_i);
      chk("eoc high", 16'h0001, {15'h0, eoc});
      hold_t = t;
      hold_f = f;
    end
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    chk("eoc", 16'h0001, {15'h0, eoc});
    chk("dac", 16'h0000, {4'h0, dac});
    chk("sample", 16'h0000, {15'h0, smp});
    chk("oe", 16'h0000, {15'h0, dout_oe});
  endtask
  // Each frame reads the word converted under the previous format
  task automatic t_formats();
    logic [2:0] fm [7] = '{3'h0, 3'h3, 3'h6, 3'h7, 3'h1, 3'h2, 3'h4};
    for (int i = 0; i < 7; i++)
      run(4'(i * 3 + 2), fm[i], flen(fm[i]), 0, 12'(i * 741 + 287));
  endtask
  task automatic t_short();
    run(4'h6, 3'h0, 10, 0, 12'hABC);
    run(4'h9, 3'h0, 12, 0, 12'h5A5);
  endtask
  task automatic t_early();
    run(4'hF, 3'h0, 12, 3, 12'hFFF);
    run(4'h0, 3'h0, 12, 0, 12'h000);
  endtask
  initial begin
    nrst_i = 1'b0;
    target = 12'h000;
    cmp = 1'b0;
    hold_t = HOLD_RST;
    hold_f = FMT_RST;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_formats();
    t_short();
    t_early();
    finish_test();
  end
  // About 5 us per frame, so this leaves wide margin
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
endmodule
bind adc_serial_ctrl adc_serial_ctrl_chk u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .din_i(din_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .eoc_o(eoc_o),
  .mux_addr_o(mux_addr_o), .sample_o(sample_o),
  .dac_code_o(dac_code_o), .cmp_i(cmp_i));
